// *** design/pcr_ctrl.sv ***
`timescale 1ns/1ps
// What this block does
// - System clock select picks PLL output 20.48 to 49.152 MHz, readable back.
// - After reset the system clock is 24.576 MHz and CPU divide is 8.
// - Every wakeup restarts the CPU clock at system clock divided by 8.
// - A 2 Hz tick derived from the 32 kHz clock, for time and wakeup.
// - Writing 5555 to the sleep command stops the CPU clock, enters standby.
// - In standby memory and pin state are held until wakeup.
// - Wakeup sources: port A change, timebase tick, fast and eight normal interrupts.
// - Key wakeup raised when port A differs from the last latched read.
// - After wakeup the CPU resumes after the sleep instruction, no reset.
// - Software may keep or stop the 32 kHz oscillator during standby.
// - Accepted sleep turns the PLL off, then enters sleep.
// - Wakeup re-enables the PLL; the CPU clock then restarts one cycle later.
// - Four voltage detect thresholds 2.6, 2.8, 3.0, 3.2 V selectable.
// - Bit 12 of voltage detect control reads one while supply is below threshold.
// - Supply below low-voltage reset level generates a system reset.
// - Enabled watchdog overflow asserts a system reset.
// - Writing 5555 to soft reset command resets as the external pin does.
// - A soft reset sets a flag in the system voltage control register.
// - External reset input is active low.
// - Base oscillator runs at nominal 32768 Hz.
module pcr_ctrl
   import pcr_pkg::*;
#(
   parameter int WDT_CYCLES = PCR_WDT_CYC,
   parameter int TICK_DIV   = PCR_TICK_DIV
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        external_reset_n,
   // Analogue comparators and base oscillator
   input  wire logic        base_clk_edge,
   input  wire logic [3:0]  below_level,
   input  wire logic        low_voltage_reset,
   // System clock select register
   input  wire logic        sysclk_we,
   input  wire logic [3:0]  sysclk_sel_wdata,
   input  wire logic [2:0]  cpudiv_wdata,
   output logic      [3:0]  system_clock_select_reg,
   output logic      [2:0]  cpu_div,
   // Command registers
   input  wire logic        sleep_we,
   input  wire logic        soft_reset_we,
   input  wire logic [15:0] cmd_wdata,
   // Port A wakeup
   input  wire logic [15:0] port_a_pins,
   input  wire logic        port_a_read,
   input  wire logic        key_wake_en,
   output logic      [15:0] port_a_data_reg,
   // Interrupt wakeup sources
   input  wire logic        fast_interrupt,
   input  wire logic [7:0]  irq,
   input  wire logic        tick_wake_en,
   // Oscillator in standby
   input  wire logic        osc_keep_we,
   input  wire logic        osc_keep_wdata,
   // Voltage detect control
   input  wire logic        lvd_we,
   input  wire logic [1:0]  lvd_sel_wdata,
   output logic      [15:0] voltage_detect_control_reg,
   // System voltage control
   input  wire logic        sysv_we,
   input  wire logic        sysv_flag_wdata,
   output logic      [15:0] system_voltage_control_reg,
   // Watchdog
   input  wire logic        wdt_enable,
   input  wire logic        wdt_clear,
   // Status and clock gates
   output logic             pll_on,
   output logic             cpu_clk_en,
   output logic             osc_on,
   output logic             tick_2hz,
   output logic             key_wake,
   output logic             in_standby,
   output logic             sys_reset
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   pcr_state_t  st_q;
   pcr_state_t  st_d;
   logic [3:0]  sel_q;
   logic [2:0]  div_q;
   logic [1:0]  lvd_sel_q;
   logic        lvd_flag_q;
   logic        soft_flag_q;
   logic        osc_keep_q;
   logic [15:0] latch_q;
   logic [31:0] wdt_q;
   logic [4:0]  hold_q;
   logic        key_q;
   logic        tick;

   // True while the processor is running normally
   function automatic logic is_running(input pcr_state_t s);
      is_running = (s == PCR_RUN);
   endfunction

   // ----------------------------------------------------------------------
   // Reset sources
   // ----------------------------------------------------------------------
   logic cmd_ok;
   logic soft_hit;
   logic sleep_hit;
   logic wdt_ovf;
   logic any_rst;

   assign cmd_ok    = (cmd_wdata == PCR_CMD_KEY);
   assign soft_hit  = soft_reset_we && cmd_ok;
   assign sleep_hit = sleep_we && cmd_ok && is_running(st_q);
   assign wdt_ovf   = wdt_enable && (wdt_q == 32'(WDT_CYCLES - 1));
   assign any_rst   = rst || !external_reset_n || low_voltage_reset || wdt_ovf || soft_hit;

   // Stretch any reset so the system sees a clean pulse
   always_ff @(posedge clock) begin
      if (rst) begin
         hold_q <= 5'(PCR_RST_HOLD);
      end else if (any_rst) begin
         hold_q <= 5'(PCR_RST_HOLD);
      end else if (hold_q != 5'h00) begin
         hold_q <= hold_q - 5'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Soft reset flag survives its own reset
   // ----------------------------------------------------------------------
   // flag set on soft reset
   always_ff @(posedge clock) begin
      if (rst || !external_reset_n || low_voltage_reset) begin
         soft_flag_q <= 1'b0;
      end else if (soft_hit) begin
         soft_flag_q <= 1'b1;
      end else if (sysv_we) begin
         soft_flag_q <= sysv_flag_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // Watchdog counter
   // ----------------------------------------------------------------------
   // Keeps counting in standby, so disable it before a long sleep
   // cleared by software
   always_ff @(posedge clock) begin
      if (any_rst || !wdt_enable || wdt_clear) begin
         wdt_q <= 32'h0000_0000;
      end else begin
         wdt_q <= wdt_q + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------------
   // Clock select and divider
   // ----------------------------------------------------------------------
   logic sel_ok;
   assign sel_ok = (sysclk_sel_wdata >= PCR_SYSCLK_MIN) && (sysclk_sel_wdata <= PCR_SYSCLK_MAX);

   always_ff @(posedge clock) begin
      if (any_rst) begin
         sel_q <= PCR_SYSCLK_RST;
         div_q <= PCR_CPUDIV_RST;
      end else if (st_q == PCR_WAKE) begin
         div_q <= PCR_CPUDIV_WAKE;
      end else if (sysclk_we && is_running(st_q)) begin
         if (sel_ok) begin
            sel_q <= sysclk_sel_wdata;
         end
         div_q <= cpudiv_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // Voltage detection and standby oscillator choice
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (any_rst) begin
         lvd_sel_q  <= PCR_LVD_SEL_RST;
         lvd_flag_q <= 1'b0;
         osc_keep_q <= 1'b1;
      end else begin
         if (lvd_we) begin
            lvd_sel_q <= lvd_sel_wdata;
         end
         lvd_flag_q <= below_level[lvd_sel_q];
         if (osc_keep_we) begin
            osc_keep_q <= osc_keep_wdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Port A latch and key wakeup
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (any_rst) begin
         latch_q <= 16'h0000;
         key_q   <= 1'b0;
      end else begin
         if (port_a_read) begin
            latch_q <= port_a_pins;
         end
         // Level output: stays up while the pins differ from the latch
         // mismatch with latched state
         key_q <= key_wake_en && (port_a_pins != latch_q);
      end
   end

   // ----------------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------------
   // Divider restarts each time the oscillator is stopped
   // half-second tick
   pcr_tick_div #(
      .DIV       (TICK_DIV)
   ) u_tick (
      .clock     (clock),
      .rst       (any_rst),
      .base_edge (base_clk_edge),
      .run       (osc_on),
      .tick      (tick)
   );

   // ----------------------------------------------------------------------
   // Sleep sequencer
   // ----------------------------------------------------------------------
   logic wake_src;
   assign wake_src = key_q || (tick_wake_en && tick) || fast_interrupt || (|irq);

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         PCR_RUN: begin
            if (sleep_hit) begin
               st_d = PCR_PLLOF;
            end
         end
         PCR_PLLOF: begin
            st_d = PCR_SLEEP;
         end
         PCR_SLEEP: begin
            if (wake_src) begin
               st_d = PCR_WAKE;
            end
         end
         PCR_WAKE: begin
            st_d = PCR_RUN;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (any_rst) begin
         st_q <= PCR_RUN;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------------
   // Next-state decodes for the registered outputs
   // ----------------------------------------------------------------------
   logic        nxt_run;
   logic        nxt_sleep;
   logic        pll_d;
   logic        osc_d;
   logic        sys_reset_d;
   logic [15:0] vdc_word;
   logic [15:0] svc_word;

   // Decode the next state so each gate moves on the same edge as the state
   assign nxt_run     = is_running(st_d);
   assign nxt_sleep   = (st_d == PCR_SLEEP);
   // PLL off in the shutdown step and in sleep
   assign pll_d       = nxt_run || (st_d == PCR_WAKE);
   // oscillator stops in sleep only if software chose so
   assign osc_d       = !(nxt_sleep && !osc_keep_q);
   // System reset stands until the stretch counter nearly runs out
   assign sys_reset_d = any_rst || (hold_q > 5'h01);

   // Readback words: select in [1:0], below flag in bit 12, soft flag in bit 0
   assign vdc_word    = {3'h0, lvd_flag_q, 10'h000, lvd_sel_q};
   assign svc_word    = {15'h0000, soft_flag_q};

   // ----------------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         pll_on      <= 1'b1;
         cpu_clk_en  <= 1'b1;
         osc_on      <= 1'b1;
         in_standby  <= 1'b0;
         sys_reset   <= 1'b1;
      end else begin
         pll_on      <= pll_d;
         cpu_clk_en  <= nxt_run;
         osc_on      <= osc_d;
         in_standby  <= nxt_sleep;
         sys_reset   <= sys_reset_d;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         system_clock_select_reg    <= PCR_SYSCLK_RST;
         cpu_div                    <= PCR_CPUDIV_RST;
         port_a_data_reg            <= 16'h0000;
         voltage_detect_control_reg <= 16'h0000;
         system_voltage_control_reg <= 16'h0000;
         tick_2hz                   <= 1'b0;
         key_wake                   <= 1'b0;
      end else begin
         system_clock_select_reg    <= sel_q;
         cpu_div                    <= div_q;
         port_a_data_reg            <= latch_q;
         voltage_detect_control_reg <= vdc_word;
         system_voltage_control_reg <= svc_word;
         tick_2hz                   <= tick;
         key_wake                   <= key_q;
      end
   end
endmodule

// *** design/pcr_pkg.sv ***
package pcr_pkg;
   // ----------------------------------------------------------------------
   // Command patterns
   // ----------------------------------------------------------------------
   localparam logic [15:0] PCR_CMD_KEY        = 16'h5555;

   // ----------------------------------------------------------------------
   // Clock defaults
   // ----------------------------------------------------------------------
   localparam int          PCR_CLK_MHZ        = 250;
   localparam logic [3:0]  PCR_SYSCLK_RST     = 4'h1;   // 24.576 MHz step
   localparam logic [3:0]  PCR_SYSCLK_MIN     = 4'h0;   // 20.48 MHz step
   localparam logic [3:0]  PCR_SYSCLK_MAX     = 4'h7;   // 49.152 MHz step
   localparam logic [2:0]  PCR_CPUDIV_RST     = 3'h3;   // divide by 8
   localparam logic [2:0]  PCR_CPUDIV_WAKE    = 3'h3;   // divide by 8

   // ----------------------------------------------------------------------
   // Base oscillator and timebase
   // ----------------------------------------------------------------------
   localparam int          PCR_BASE_HZ        = 32768;
   localparam int          PCR_TICK_HZ        = 2;
   localparam int          PCR_TICK_DIV       = PCR_BASE_HZ / PCR_TICK_HZ;

   // ----------------------------------------------------------------------
   // Voltage detect control fields
   // ----------------------------------------------------------------------
   localparam int          PCR_LVD_FLAG_BIT   = 12;
   localparam logic [1:0]  PCR_LVD_SEL_RST    = 2'h0;   // 2.6 V
   localparam int          PCR_SOFT_FLAG_BIT  = 0;

   // ----------------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------------
   localparam int          PCR_WDT_MS         = 1000;
   localparam int          PCR_WDT_CYC        = PCR_WDT_MS * 1000 * PCR_CLK_MHZ;
   localparam int          PCR_RST_HOLD       = 16;

   typedef enum logic [1:0] {
      PCR_RUN   = 2'b00,
      PCR_PLLOF = 2'b01,
      PCR_SLEEP = 2'b10,
      PCR_WAKE  = 2'b11
   } pcr_state_t;
endpackage

// *** design/pcr_tick_div.sv ***
`timescale 1ns/1ps
module pcr_tick_div
   import pcr_pkg::*;
#(
   parameter int DIV = PCR_TICK_DIV
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Base clock edge and enable
   input  wire logic base_edge,
   input  wire logic run,
   // Tick out
   output logic      tick
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        wrap;

   // Count base edges, wrap every half second
   assign wrap  = base_edge && (cnt_q == 16'(DIV - 1));
   assign cnt_d = wrap ? 16'h0000 : (base_edge ? cnt_q + 16'h0001 : cnt_q);

   // Counter and one-cycle tick
   always_ff @(posedge clock) begin
      if (rst || !run) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= wrap;
      end
   end
endmodule

// *** tb/pcr_checker.sv ***
`timescale 1ns/1ps
module pcr_checker
   import pcr_pkg::*;
(
   // Clock and reset sources
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        external_reset_n,
   input wire logic        low_voltage_reset,
   input wire logic        sys_reset,
   // Writes and commands
   input wire logic        sysclk_we,
   input wire logic [3:0]  sysclk_sel_wdata,
   input wire logic        sleep_we,
   input wire logic        soft_reset_we,
   input wire logic [15:0] cmd_wdata,
   // Levels and readbacks
   input wire logic [3:0]  below_level,
   input wire logic        fast_interrupt,
   input wire logic [7:0]  irq,
   input wire logic [3:0]  system_clock_select_reg,
   input wire logic [2:0]  cpu_div,
   input wire logic [15:0] voltage_detect_control_reg,
   input wire logic [15:0] system_voltage_control_reg,
   // Clock gates
   input wire logic        pll_on,
   input wire logic        cpu_clk_en,
   input wire logic        in_standby
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // Running, with no reset source pending
   wire logic run_ok = cpu_clk_en && pll_on && !in_standby && !sys_reset
      && external_reset_n && !low_voltage_reset;
   wire logic key_hit = (cmd_wdata == PCR_CMD_KEY);

   // Standby entry and wakeup steps
   sequence s_enter;
      !cpu_clk_en ##1 (!pll_on && in_standby);
   endsequence
   sequence s_wake;
      (pll_on && !in_standby) ##1 cpu_clk_en ##[0:2] (cpu_div == PCR_CPUDIV_WAKE);
   endsequence

   a_sleep_enters: assert property (
      sleep_we && key_hit && !soft_reset_we && run_ok |=> s_enter)
      else $error("sleep command did not enter standby");
   a_bad_cmd_ignored: assert property (
      (sleep_we || soft_reset_we) && !key_hit && run_ok |=> cpu_clk_en && !sys_reset)
      else $error("wrong command value acted on");
   a_soft_reset_flag: assert property (
      soft_reset_we && key_hit && run_ok
      |=> sys_reset ##1 system_voltage_control_reg[PCR_SOFT_FLAG_BIT])
      else $error("soft reset or its flag missing");
   a_pin_reset_defaults: assert property (
      !external_reset_n [*3] |-> sys_reset && system_clock_select_reg == PCR_SYSCLK_RST
      && cpu_div == PCR_CPUDIV_RST)
      else $error("pin reset did not restore clocks");
   a_supply_reset_defaults: assert property (
      low_voltage_reset [*3] |-> sys_reset && system_clock_select_reg == PCR_SYSCLK_RST)
      else $error("supply reset did not reset");
   a_detect_flag_follows: assert property (
      (!sys_reset && $stable(below_level) && $stable(voltage_detect_control_reg[1:0])) [*3]
      |-> voltage_detect_control_reg[PCR_LVD_FLAG_BIT]
      == below_level[voltage_detect_control_reg[1:0]])
      else $error("voltage flag does not follow threshold");
   a_wake_restarts_clock: assert property (
      in_standby && (fast_interrupt || (|irq)) |=> s_wake)
      else $error("wakeup sequence wrong");
   a_sel_taken: assert property (
      sysclk_we && sysclk_sel_wdata <= PCR_SYSCLK_MAX && run_ok
      |-> ##2 system_clock_select_reg == $past(sysclk_sel_wdata, 2))
      else $error("clock select not taken");
endmodule

bind pcr_ctrl pcr_checker u_pcr_checker (.*);

// *** tb/pcr_cpu_model.sv ***
`timescale 1ns/1ps
module pcr_cpu_model (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Requests from the bench
   input  wire logic        req_latch,
   input  wire logic        req_sleep,
   input  wire logic        req_soft,
   input  wire logic [15:0] req_val,
   input  wire logic        kick_en,
   // Writes towards the block
   output logic             port_a_read = 1'b0,
   output logic             sleep_we = 1'b0,
   output logic             soft_reset_we = 1'b0,
   output logic      [15:0] cmd_wdata = 16'h0000,
   output logic             wdt_clear = 1'b0
);
   logic       pend_q = 1'b0;
   logic [5:0] kick_q = 6'h00;

   always_ff @(posedge clock) begin
      port_a_read   <= req_latch || req_sleep;
      pend_q        <= req_sleep;
      sleep_we      <= pend_q;
      soft_reset_we <= req_soft;
      cmd_wdata     <= (pend_q || req_soft) ? req_val : ~cmd_wdata; // Idle value keeps moving
   end

   always_ff @(posedge clock) begin
      kick_q    <= rst ? 6'h00 : kick_q + 6'h01;
      wdt_clear <= kick_en && (kick_q == 6'h00);
   end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench
   import pcr_pkg::*;
;
   // Bench driven inputs
   logic clock = 1'b0, rst = 1'b1, external_reset_n = 1'b1, low_voltage_reset = 1'b0;
   logic base_clk_edge = 1'b0, sysclk_we = 1'b0, lvd_we = 1'b0, osc_keep_we = 1'b0;
   logic sysv_we = 1'b0, key_wake_en = 1'b0, fast_interrupt = 1'b0, tick_wake_en = 1'b0;
   logic wdt_enable = 1'b0, osc_keep_wdata = 1'b1, sysv_flag_wdata = 1'b0, kick_en = 1'b0;
   logic req_latch = 1'b0, req_sleep = 1'b0, req_soft = 1'b0;
   logic [3:0]  below_level = 4'h0, sysclk_sel_wdata = 4'h1;
   logic [2:0]  cpudiv_wdata = 3'h3;
   logic [1:0]  lvd_sel_wdata = 2'h0;
   logic [7:0]  irq = 8'h00;
   logic [15:0] port_a_pins = 16'h0000, req_val = 16'h0000, cmd_wdata;
   // Model and design outputs
   logic port_a_read, sleep_we, soft_reset_we, wdt_clear, pll_on, cpu_clk_en, osc_on;
   logic tick_2hz, key_wake, in_standby, sys_reset;
   logic [3:0]  system_clock_select_reg;
   logic [2:0]  cpu_div;
   logic [15:0] port_a_data_reg, voltage_detect_control_reg, system_voltage_control_reg;
   int bad_count = 0, n_tests = 0, osc_cnt = 0, n;
   localparam logic [15:0] DFLT = 16'({PCR_SYSCLK_RST, PCR_CPUDIV_RST});

   pcr_ctrl #(.WDT_CYCLES(100), .TICK_DIV(4)) u_pcr_ctrl (.*);
   pcr_cpu_model u_pcr_cpu_model (.*);

   // Clock, and a base oscillator edge every 8 clocks
   always #2 clock = ~clock;
   always @(posedge clock) begin
      #1;
      osc_cnt = osc_cnt + 1;
      base_clk_edge = (osc_cnt % 8 == 0);
   end

   // Step to just after a rising edge
   task cyc(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic await(ref logic s, input logic v, input int lim);
      for (int i = 0; i < lim && s !== v; i++)
         cyc(1);
      if (s !== v) begin
         bad_count++;
         $display("wrong value at %0t: wait ran out", $time);
         summarize();
      end
   endtask
   // Register write: k 0 clock select, 1 voltage detect, 2 oscillator, 3 soft flag
   task wr(input int k, input logic [3:0] v);
      sysclk_sel_wdata = v;
      lvd_sel_wdata = v[1:0];
      osc_keep_wdata = v[0];
      sysv_flag_wdata = v[0];
      {sysclk_we, lvd_we, osc_keep_we, sysv_we} = 4'h8 >> k;
      cyc(1);
      {sysclk_we, lvd_we, osc_keep_we, sysv_we} = 4'h0;
      cyc(1);
   endtask
   // Processor request: k 0 latch port A, 1 sleep, 2 soft reset
   task cmd(input int k, input logic [15:0] v);
      req_val = v;
      {req_latch, req_sleep, req_soft} = 3'h4 >> k;
      cyc(1);
      {req_latch, req_sleep, req_soft} = 3'h0;
      cyc(3);
   endtask

   // Main sequence
   initial begin
      cyc(6);
      rst = 1'b0;
      await(sys_reset, 1'b0, 40);
      check(16'({system_clock_select_reg, cpu_div}), DFLT);
      $display("defaults done");
      for (int i = 0; i < 9; i++) begin
         wr(0, 4'(i));
         check(16'(system_clock_select_reg), (i < 8) ? 16'(i) : 16'h0007);
      end
      $display("clock select done");
      below_level = 4'hA;
      for (int s = 0; s < 4; s++) begin
         wr(1, 4'(s));
         cyc(2);
         check(voltage_detect_control_reg & 16'h1003, 16'(s) | {3'h0, below_level[s], 12'h0});
      end
      cmd(1, 16'h5554);
      check(16'(cpu_clk_en), 16'h0001);
      cmd(2, 16'hAAAA);
      check(16'(sys_reset), 16'h0000);
      $display("detect and refusals done");
      port_a_pins = 16'h0F0F;
      key_wake_en = 1'b1;
      cpudiv_wdata = 3'h0;
      wr(0, 4'h5);
      cmd(1, PCR_CMD_KEY);
      await(in_standby, 1'b1, 10);
      check(16'({cpu_clk_en, pll_on}), 16'h0000);
      cyc(5);
      check(port_a_data_reg, 16'h0F0F);
      check(16'(in_standby), 16'h0001);
      port_a_pins = 16'h0F0E;
      await(in_standby, 1'b0, 10);
      check(16'(key_wake), 16'h0001);
      await(cpu_clk_en, 1'b1, 5);
      cyc(2);
      check(16'({pll_on, cpu_div}), 16'(PCR_CPUDIV_WAKE) | 16'h0008);
      check(16'({sys_reset, system_clock_select_reg}), 16'h0005);
      cmd(0, 16'h0000);
      check(16'(key_wake), 16'h0000);
      $display("key wakeup done");
      wr(2, 4'h0);
      for (int i = 0; i < 9; i++) begin
         cmd(1, PCR_CMD_KEY);
         await(in_standby, 1'b1, 10);
         check(16'(osc_on), 16'h0000);
         {irq, fast_interrupt} = 9'h001 << i;
         await(in_standby, 1'b0, 10);
         check(16'(pll_on), 16'h0001);
         {irq, fast_interrupt} = 9'h000;
         cyc(3);
      end
      wr(2, 4'h1);
      check(16'(osc_on), 16'h0001);
      tick_wake_en = 1'b1;
      cmd(1, PCR_CMD_KEY);
      await(in_standby, 1'b1, 10);
      check(16'(osc_on), 16'h0001);
      await(in_standby, 1'b0, 100);
      tick_wake_en = 1'b0;
      await(tick_2hz, 1'b1, 100);
      cyc(1);
      for (n = 1; n < 100 && tick_2hz !== 1'b1; n++)
         cyc(1);
      check(16'(n), 16'h0020);
      $display("wake sources done");
      cmd(2, PCR_CMD_KEY);
      await(sys_reset, 1'b0, 40);
      check(16'({system_clock_select_reg, cpu_div}), DFLT);
      check(16'(system_voltage_control_reg[0]), 16'h0001);
      for (int k = 0; k < 2; k++) begin
         wr(0, 4'h6);
         {external_reset_n, low_voltage_reset} = {k[0], k[0]};
         cyc(4);
         check(16'(sys_reset), 16'h0001);
         {external_reset_n, low_voltage_reset} = 2'b10;
         await(sys_reset, 1'b0, 40);
         check(16'({system_clock_select_reg, cpu_div, system_voltage_control_reg[0]}), DFLT << 1);
      end
      $display("reset sources done");
      wr(0, 4'h6);
      wdt_enable = 1'b1;
      kick_en = 1'b1;
      cyc(400);
      check(16'(sys_reset), 16'h0000);
      kick_en = 1'b0;
      await(sys_reset, 1'b1, 150);
      wdt_enable = 1'b0;
      await(sys_reset, 1'b0, 40);
      check(16'({system_clock_select_reg, cpu_div}), DFLT);
      $display("watchdog done");
      summarize();
   end
endmodule
